// *** dbm_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// cable mapping, boot choice and status checks at the top ports
module dbm_chk
  import dbm_pkg::*;
(
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // straps and cable
  input wire logic [5:0] strap_i,
  input wire logic       stat_pin_i,
  input wire logic [3:0] sel_line_o,
  input wire logic       head_line_o,
  input wire logic       ds4_alt_line_o,
  input wire logic       track_beyond_fortythree_line_o,
  input wire logic       side_line_o,
  input wire logic       fast_seek_o,
  input wire logic       boot_loader_o,
  input wire logic       boot_monitor_o
);
  logic [2:0] age_reg; // edges since reset, saturating
  logic [5:0] st_reg;  // straps as first seen, later edits ignored
  logic [7:0] sel_m;   // select register mirror
  logic [7:0] c2_m;    // control two mirror
  logic [9:0] ej_m;    // eject cycles left
  logic [7:0] sel_reg; // select mirror as the cable shows it
  logic [7:0] c2_reg;  // control two as the cable shows it
  logic [9:0] ej_reg;  // eject count as the cable shows it
  logic [3:0] oh;      // lowest requested drive wins
  logic       rdy;     // mapping settled after strap latch
  assign oh  = sel_reg[3:0] & (~sel_reg[3:0] + 4'h1);
  assign rdy = (age_reg >= 3'h5);
  // mirrors follow writes; eject only counts with the strap in
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age_reg <= 3'h0;
      st_reg  <= 6'h00;
      sel_m   <= DBM_SEL_RESET;
      c2_m    <= DBM_CTRL2_RESET;
      ej_m    <= 10'h000;
      sel_reg <= DBM_SEL_RESET;
      c2_reg  <= DBM_CTRL2_RESET;
      ej_reg  <= 10'h000;
    end else begin
      if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
      if (age_reg == 3'h1) st_reg <= strap_i;
      if (wr_i && addr_i == DBM_OFF_SELECT) sel_m <= wdata_i;
      if (wr_i && addr_i == DBM_OFF_CTRL2) c2_m <= wdata_i;
      if (wr_i && addr_i == DBM_OFF_EJECT && wdata_i[0] && st_reg[2]) ej_m <= 10'(DBM_EJECT_CYC);
      else if (ej_m != 10'h000) ej_m <= ej_m - 10'h001;
      // cable pins are registered once more than the registers
      sel_reg <= sel_m;
      c2_reg  <= c2_m;
      ej_reg  <= ej_m;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pin_still; $stable(stat_pin_i) [*5]; endsequence
  sequence s_stat_rd; rdy && rd_i && addr_i == DBM_OFF_STATUS; endsequence
  property p_fast; rdy |-> fast_seek_o == (st_reg[3] | ~c2_reg[DBM_CTRL2_FAST_BIT]); endproperty
  property p_sel; rdy |-> sel_line_o == (st_reg[4] ? {1'b0, oh[2:0]} : oh); endproperty
  property p_head;
    rdy |-> head_line_o == (st_reg[5] ? oh[2] : sel_reg[DBM_SEL_HEAD_BIT]);
  endproperty
  property p_ds4; rdy |-> ds4_alt_line_o == (st_reg[4] & oh[3]); endproperty
  property p_tg;
    rdy |-> track_beyond_fortythree_line_o == sel_reg[st_reg[5] ? DBM_SEL_SIDE_BIT : DBM_SEL_TRACK_BEYOND_FORTYTHREE_BIT];
  endproperty
  property p_side;
    rdy |-> side_line_o == (st_reg[2] ? (ej_reg != 10'h000 && |oh) : sel_reg[DBM_SEL_SIDE_BIT]);
  endproperty
  property p_boot; rdy |-> boot_loader_o == st_reg[0] && boot_monitor_o != st_reg[0]; endproperty
  property p_stat;
    s_pin_still ##0 s_stat_rd |=> rdata_o[2:1] ==
      (st_reg[1] ? {$past(stat_pin_i), 1'b0} : {1'b1, $past(stat_pin_i)});
  endproperty
  a_fast: assert property (p_fast) else $error("fast seek level wrong");
  a_sel: assert property (p_sel) else $error("drive select lines wrong");
  a_head: assert property (p_head) else $error("head line wrong");
  a_ds4: assert property (p_ds4) else $error("relocated select wrong");
  a_tg: assert property (p_tg) else $error("track line wrong");
  a_side: assert property (p_side) else $error("side or eject line wrong");
  a_boot: assert property (p_boot) else $error("boot choice wrong");
  a_stat: assert property (p_stat) else $error("status meaning wrong");
endmodule // dbm_chk
`default_nettype wire

// *** dbm_drives.sv ***
`timescale 1ns/1ps
`default_nettype none
// four drives on the cable sharing status and track-zero lines
module dbm_drives
  import dbm_pkg::*;
(
  // cable side
  input  wire logic [3:0] sel_i,   // one select line per drive
  input  wire logic [3:0] dual_i,  // drives holding two-sided media
  output logic            stat_o,  // status line, pulled up
  output logic            track0_o // heads parked on track zero
);
  // unselected drives release the lines, so the pull-up wins
  always_comb begin
    stat_o   = 1'b1;
    track0_o = 1'b1;
    if (sel_i != 4'h0) begin
      stat_o = |(sel_i & dual_i);
    end
  end
endmodule // dbm_drives
`default_nettype wire

// *** dbm_geom.sv ***
`timescale 1ns/1ps
`default_nettype none
// sectors per track for a format code, registered
module dbm_geom
  import dbm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // format code
  input  wire logic [3:0] fmt_i,
  output logic      [7:0] spt_o,
  output logic            legal_o
);
  logic [7:0] spt_reg;
  logic [7:0] spt_next;
  logic       legal_reg;
  logic       legal_next;
  logic [1:0] step;  // size code minus density offset
  // table lookup; double density shifts the size code down one
  always_comb begin
    step       = fmt_i[1:0] - {1'b0, fmt_i[2]};
    legal_next = !(fmt_i[2] && fmt_i[1:0] == 2'h0);  // dd has no 128-byte sectors
    spt_next   = 8'h00;
    if (legal_next) begin
      if (fmt_i[3]) begin
        case (step)
          2'h0:    spt_next = 8'h1a;
          2'h1:    spt_next = 8'h0f;
          2'h2:    spt_next = 8'h08;
          default: spt_next = 8'h04;
        endcase
      end else begin
        case (step)
          2'h0:    spt_next = 8'h12;
          2'h1:    spt_next = 8'h0a;
          2'h2:    spt_next = 8'h05;
          default: spt_next = 8'h02;
        endcase
      end
    end
  end
  // registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spt_reg   <= 8'h00;
      legal_reg <= 1'b0;
    end else begin
      spt_reg   <= spt_next;
      legal_reg <= legal_next;
    end
  end
  assign spt_o   = spt_reg;
  assign legal_o = legal_reg;
endmodule : dbm_geom
`default_nettype wire

// *** dbm_pkg.sv ***
package dbm_pkg;
  // register offsets on the plain port
  localparam logic [7:0] DBM_OFF_CTRL2   = 8'h00;
  localparam logic [7:0] DBM_OFF_EJECT   = 8'h04;
  localparam logic [7:0] DBM_OFF_SELECT  = 8'h08;
  localparam logic [7:0] DBM_OFF_FORMAT  = 8'h0c;
  localparam logic [7:0] DBM_OFF_STATUS  = 8'h10;
  localparam logic [7:0] DBM_OFF_GEOM    = 8'h14;
  // control register 2 fields
  localparam int         DBM_CTRL2_FAST_BIT  = 4;
  localparam logic [7:0] DBM_CTRL2_RESET     = 8'h10;
  // select register fields
  localparam int         DBM_SEL_SIDE_BIT    = 4;
  localparam int         DBM_SEL_TRACK_BEYOND_FORTYTHREE_BIT    = 5;
  localparam int         DBM_SEL_HEAD_BIT    = 6;
  localparam logic [7:0] DBM_SEL_RESET       = 8'h00;
  // format register: [1:0] size code, [2] double density, [3] 8-inch
  localparam logic [7:0] DBM_FMT_RESET       = 8'h00;
  localparam int         DBM_NUM_DRIVES      = 4;
  // eject pulse length
  localparam int         DBM_EJECT_NS        = 1000;
  localparam int         DBM_CLK_NS          = 4;
  localparam int         DBM_EJECT_CYC       = (DBM_EJECT_NS + DBM_CLK_NS - 1) / DBM_CLK_NS;
  // boot entry choices
  typedef enum logic [1:0] {DBM_BOOT_IDLE, DBM_BOOT_LOADER, DBM_BOOT_MONITOR} dbm_boot_e;
  // strap bundle
  typedef struct packed {
    logic voice_coil;  // remap cable lines
    logic ds4_reloc;   // fourth select on relocated line
    logic fast_perm;   // fast seek forced on
    logic eject_en;    // eject option strapped in
    logic seek_stat;   // status input means seek done
    logic auto_boot;   // boot system directly
  } dbm_strap_s;
  // cable outputs
  typedef struct packed {
    logic [3:0] sel_line;     // four select lines, default positions
    logic       head_line;    // head-engage line
    logic       ds4_alt_line; // relocated fourth select line
    logic       track_beyond_fortythree_line;    // track-beyond-43 line
    logic       side_line;    // side select line
    logic       fast_seek;    // fast positioning
  } dbm_cable_s;
endpackage : dbm_pkg

// *** dbm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of pin levels
module dbm_sync
  import dbm_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;  // first stage, read only by second
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  // next values
  always_comb begin
    meta_next = d_i;
    q_next    = meta_reg;
  end
  // registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end
  assign q_o = q_reg;
endmodule : dbm_sync
`default_nettype wire

// *** dbm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// drive cable option mapping with strap sampling and boot choice
module dbm_top
  import dbm_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // straps, static pins
  input  wire logic [5:0] strap_i,
  // drive status pins
  input  wire logic       stat_pin_i,
  input  wire logic       track0_i,
  // drive cable
  output logic      [3:0] sel_line_o,
  output logic            head_line_o,
  output logic            ds4_alt_line_o,
  output logic            track_beyond_fortythree_line_o,
  output logic            side_line_o,
  output logic            fast_seek_o,
  // boot entry
  output logic            boot_loader_o,
  output logic            boot_monitor_o
);
  // synchronised pins
  // straps and drive status come from outside the clock domain,
  // so both pass two flops before any logic reads them
  logic [5:0] strap_sync;
  logic [1:0] stat_sync;
  dbm_sync #(.W(6)) u_strap_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (strap_i),
    .q_o     (strap_sync)
  );
  dbm_sync #(.W(2)) u_stat_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({track0_i, stat_pin_i}),
    .q_o     (stat_sync)
  );

  // straps latched once after reset
  // the straps are solder links, so one clean sample is enough;
  // freezing it keeps a loose link from remapping the cable
  // in the middle of a transfer
  // a strap change therefore needs a reset to take effect
  dbm_strap_s strap_reg;
  dbm_strap_s strap_next;
  logic [1:0] lat_cnt_reg;   // waits for synchroniser to fill
  logic [1:0] lat_cnt_next;
  logic       lat_done;
  assign lat_done = (lat_cnt_reg == 2'h3);
  // sample on third edge after release, then freeze
  // two edges fill the synchroniser, the third takes the level
  // the counter stops at three and holds until the next reset
  always_comb begin
    strap_next   = strap_reg;
    lat_cnt_next = lat_cnt_reg;
    if (!lat_done) begin
      lat_cnt_next = lat_cnt_reg + 2'h1;
      if (lat_cnt_reg == 2'h2) begin
        strap_next = dbm_strap_s'(strap_sync);
      end
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_reg   <= '0;
      lat_cnt_reg <= 2'h0;
    end else begin
      strap_reg   <= strap_next;
      lat_cnt_reg <= lat_cnt_next;
    end
  end

  // software registers
  // control two is a plain 8-bit word, drive select is 8 bits with a one-hot [3:0], format is 4 bits,
  // written in one cycle; none of them has side effects
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl2_next;
  logic [7:0] sel_reg;    // [3:0] drive select, [4] side, [5] track_beyond_fortythree, [6] head
  logic [7:0] sel_next;
  logic [3:0] fmt_reg;
  logic [3:0] fmt_next;
  logic       eject_req;
  // one-hot select; more than one bit keeps only the lowest
  // two drives on one cable must never be selected together,
  // so a careless write still leaves a single select line
  function automatic logic [3:0] one_hot(input logic [3:0] v);
    logic [3:0] r;
    r = 4'h0;
    if (v[0])      r = 4'h1;
    else if (v[1]) r = 4'h2;
    else if (v[2]) r = 4'h4;
    else if (v[3]) r = 4'h8;
    return r;
  endfunction
  // register writes decoded by address
  // the eject offset has no storage: a write only fires the pulse
  // unmapped offsets are ignored rather than aliased
  always_comb begin
    ctrl2_next = ctrl2_reg;
    sel_next   = sel_reg;
    fmt_next   = fmt_reg;
    eject_req  = 1'b0;
    if (wr_i) begin
      if (addr_i == DBM_OFF_CTRL2) begin
        ctrl2_next = wdata_i;
      end else if (addr_i == DBM_OFF_SELECT) begin
        sel_next = {wdata_i[7:4], one_hot(wdata_i[3:0])};
      end else if (addr_i == DBM_OFF_FORMAT) begin
        fmt_next = wdata_i[3:0];
      end else if (addr_i == DBM_OFF_EJECT) begin
        eject_req = wdata_i[0] && strap_reg.eject_en;
      end
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl2_reg <= DBM_CTRL2_RESET;
      sel_reg   <= DBM_SEL_RESET;
      fmt_reg   <= DBM_FMT_RESET[3:0];
    end else begin
      ctrl2_reg <= ctrl2_next;
      sel_reg   <= sel_next;
      fmt_reg   <= fmt_next;
    end
  end

  // eject pulse, long enough for the drive to see
  // the drive needs a level it can sample on its own clock,
  // so the one-cycle strobe is stretched to a fixed length
  // a second write before the end restarts the count
  localparam logic [9:0] EJ_LEN = 10'(DBM_EJECT_CYC);
  logic [9:0] ej_cnt_reg;
  logic [9:0] ej_cnt_next;
  logic       ej_on;
  assign ej_on = (ej_cnt_reg != 10'h000);
  // restart on each eject write
  always_comb begin
    ej_cnt_next = ej_cnt_reg;
    if (eject_req) begin
      ej_cnt_next = EJ_LEN;
    end else if (ej_on) begin
      ej_cnt_next = ej_cnt_reg - 10'h001;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ej_cnt_reg <= 10'h000;
    end else begin
      ej_cnt_reg <= ej_cnt_next;
    end
  end

  // cable line mapping
  // each convention moves a few signals to other cable pins;
  // the mapping is a pure function of the frozen straps,
  // the software registers and the eject count, registered once so that the pins
  // never glitch while the select register is rewritten
  // costs one cycle of latency after each write
  dbm_cable_s cable_reg;
  dbm_cable_s cable_next;
  // all mapping from frozen straps only
  always_comb begin
    cable_next              = '0;
    cable_next.sel_line     = sel_reg[3:0];
    cable_next.fast_seek    = strap_reg.fast_perm
                              || !ctrl2_reg[DBM_CTRL2_FAST_BIT];
    if (strap_reg.voice_coil) begin
      cable_next.head_line = sel_reg[2];
      cable_next.track_beyond_fortythree_line = sel_reg[DBM_SEL_SIDE_BIT];
    end else begin
      cable_next.head_line = sel_reg[DBM_SEL_HEAD_BIT];
      cable_next.track_beyond_fortythree_line = sel_reg[DBM_SEL_TRACK_BEYOND_FORTYTHREE_BIT];
    end
    if (strap_reg.ds4_reloc) begin
      cable_next.sel_line[3]  = 1'b0;
      cable_next.ds4_alt_line = sel_reg[3];
    end
    // eject reuses the side line toward the selected drive
    // the plain side bit then has no pin of its own
    if (strap_reg.eject_en) begin
      cable_next.side_line = ej_on && (sel_reg[3:0] != 4'h0);
    end else begin
      cable_next.side_line = sel_reg[DBM_SEL_SIDE_BIT];
    end
    if (!lat_done) begin
      cable_next = '0;  // nothing driven until straps are known
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cable_reg <= '0;
    end else begin
      cable_reg <= cable_next;
    end
  end
  assign sel_line_o     = cable_reg.sel_line;
  assign head_line_o    = cable_reg.head_line;
  assign ds4_alt_line_o = cable_reg.ds4_alt_line;
  assign track_beyond_fortythree_line_o    = cable_reg.track_beyond_fortythree_line;
  assign side_line_o    = cable_reg.side_line;
  assign fast_seek_o    = cable_reg.fast_seek;

  // boot choice, made once after straps settle
  // exactly one of the two outputs is high once the straps
  // are known; both stay low while the choice is pending, so
  // the processor side can wait for either level
  dbm_boot_e boot_reg;
  dbm_boot_e boot_next;
  always_comb begin
    boot_next = boot_reg;
    case (boot_reg)
      DBM_BOOT_IDLE: begin
        if (lat_done) begin
          if (strap_reg.auto_boot) begin
            boot_next = DBM_BOOT_LOADER;
          end else begin
            boot_next = DBM_BOOT_MONITOR;
          end
        end
      end
      default: boot_next = boot_reg;  // held until next reset
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_reg <= DBM_BOOT_IDLE;
    end else begin
      boot_reg <= boot_next;
    end
  end
  assign boot_loader_o  = (boot_reg == DBM_BOOT_LOADER);
  assign boot_monitor_o = (boot_reg == DBM_BOOT_MONITOR);

  // geometry of the programmed format
  // sectors per track are looked up from the format code;
  // the table sits in its own module to keep this one readable
  logic [7:0] spt;
  logic       fmt_legal;
  dbm_geom u_geom (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .fmt_i   (fmt_reg),
    .spt_o   (spt),
    .legal_o (fmt_legal)
  );
  // status input meaning chosen by strap
  // one pin serves two meanings; the unused meaning reads
  // as its harmless level: not two-sided, or seek already done,
  // so software written for either convention keeps working
  logic two_sided;
  logic seek_done;
  assign two_sided = strap_reg.seek_stat ? 1'b0 : stat_sync[0];
  assign seek_done = strap_reg.seek_stat ? stat_sync[0] : 1'b1;

  // read data, valid the cycle after the strobe
  // reads have no side effects, so a repeated read is safe
  // the port shows zero between reads, which keeps a shared
  // read path quiet
  // status is sampled at the strobe, not held from earlier
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      if (addr_i == DBM_OFF_CTRL2) begin
        rdata_next = ctrl2_reg;
      end else if (addr_i == DBM_OFF_SELECT) begin
        rdata_next = sel_reg;
      end else if (addr_i == DBM_OFF_FORMAT) begin
        rdata_next = {4'h0, fmt_reg};
      end else if (addr_i == DBM_OFF_STATUS) begin
        rdata_next = {boot_reg == DBM_BOOT_MONITOR, boot_reg == DBM_BOOT_LOADER,
                      ej_on, fmt_legal, stat_sync[1], seek_done, two_sided,
                      cable_reg.fast_seek};
      end else if (addr_i == DBM_OFF_GEOM) begin
        rdata_next = spt;
      end else begin
        rdata_next = 8'h00;  // unmapped reads zero
      end
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;
endmodule : dbm_top
`default_nettype wire

// *** dbm_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// random straps with register traffic across resets
module dbm_top_tb_top import dbm_pkg::*;;
  logic       mclk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [5:0] strap_i = 6'h00;
  logic       stat_pin_i, track0_i, head_line_o, ds4_alt_line_o, track_beyond_fortythree_line_o;
  logic       side_line_o, fast_seek_o, boot_loader_o, boot_monitor_o;
  logic [3:0] sel_line_o;
  logic [7:0] rdata_o;
  logic [7:0] d;         // last read value
  int         n_fail = 0;
  int         comparisons = 0;
  int         cyc = 0;   // hang guard
  int         seed = 32'hd60b;
  dbm_top dut (.*);
  // drive 0 two-sided, drive 1 not
  dbm_drives u_drv (.sel_i({sel_line_o[3] | ds4_alt_line_o, sel_line_o[2:0]}), .dual_i(4'h5),
                    .stat_o(stat_pin_i), .track0_o(track0_i));
  initial forever #2 mclk_i = ~mclk_i;
  // sectors per track; double density shifts the size code down one
  function automatic logic [7:0] spt(input logic [3:0] f);
    logic [1:0] k;
    k = f[1:0] - {1'b0, f[2]};
    if (f[2] && f[1:0] == 2'h0) return 8'h00;
    if (f[3]) return (k == 2'h0) ? 8'h1a : (k == 2'h1) ? 8'h0f : (k == 2'h2) ? 8'h08 : 8'h04;
    return (k == 2'h0) ? 8'h12 : (k == 2'h1) ? 8'h0a : (k == 2'h2) ? 8'h05 : 8'h02;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    // the cable pins follow one edge after the register
    @(posedge mclk_i);
    #1;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a hang counts against the run
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      strap_i <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      #1 chk(boot_loader_o, strap_i[0]);
      chk(boot_monitor_o, !strap_i[0]);
      rd(DBM_OFF_CTRL2);
      chk(d, DBM_CTRL2_RESET);
      rd(8'h20);
      chk(d, 8'h00);
      // track zero is laid out as single density, 128-byte sectors
      wr(DBM_OFF_FORMAT, 8'h08);
      rd(DBM_OFF_GEOM);
      chk(d, 8'h1a);
      // every size, density and diameter code
      for (int f = 0; f < 16; f++) begin
        wr(DBM_OFF_FORMAT, 8'(f));
        repeat (2) @(posedge mclk_i);
        rd(DBM_OFF_GEOM);
        chk(d, spt(4'(f)));
        rd(DBM_OFF_STATUS);
        chk(d[4], spt(4'(f)) != 8'h00);
      end
      // status pin meaning, pin given time to cross the synchroniser
      for (int s = 0; s < 2; s++) begin
        wr(DBM_OFF_SELECT, 8'(1 << s));
        repeat (4) @(posedge mclk_i);
        rd(DBM_OFF_STATUS);
        chk(d[2:1], strap_i[1] ? {s == 0, 1'b0} : {1'b1, s == 0});
        chk(d[7:6], {!strap_i[0], strap_i[0]});
      end
      // eject lasts the full pulse, only with the strap in
      wr(DBM_OFF_EJECT, 8'h01);
      chk(side_line_o, strap_i[2]);
      repeat (249) @(posedge mclk_i);
      #1 chk(side_line_o, strap_i[2]);
      @(posedge mclk_i);
      #1 chk(side_line_o, 1'b0);
      wr(DBM_OFF_CTRL2, 8'h00);
      chk(fast_seek_o, 1'b1);
      wr(DBM_OFF_CTRL2, DBM_CTRL2_RESET);
      chk(fast_seek_o, strap_i[3]);
      // two drives asked, the lower one wins
      wr(DBM_OFF_SELECT, 8'h0c);
      chk(head_line_o, strap_i[5]);
      wr(DBM_OFF_SELECT, 8'h28);
      chk(ds4_alt_line_o, strap_i[4]);
      chk(track_beyond_fortythree_line_o, !strap_i[5]);
      repeat (20) wr(DBM_OFF_SELECT, 8'($random(seed)));
      // straps moved in mid-run must not take effect
      @(posedge mclk_i);
      strap_i <= ~strap_i;
      repeat (8) @(posedge mclk_i);
      #1 chk(boot_loader_o, !strap_i[0]);
      chk(fast_seek_o, !strap_i[3]);
    end
    conclude();
  end
endmodule // dbm_top_tb_top
bind dbm_top dbm_chk u_chk (.*);
`default_nettype wire
